// ===== src/dbra_pkg.sv
// Constants and types shared by the dual bank register access block
package dbra_pkg;
	// Byte addressed space of 32 locations
	localparam int unsigned DBRA_AW = 5;
	localparam int unsigned DBRA_DW = 8;
	localparam int unsigned DBRA_CNT_W = 2;
	localparam int unsigned DBRA_MEM_DEPTH = 16;
	localparam int unsigned DBRA_SYNC_W = 10;

	localparam logic [4:0] DBRA_FIRST_ADDR = 5'h00;
	localparam logic [4:0] DBRA_LAST_ADDR = 5'h0f;
	localparam logic [4:0] DBRA_ADDR_STEP = 5'h01;
	localparam logic [4:0] DBRA_PRI_CFG1 = 5'h00;
	localparam logic [4:0] DBRA_PRI_CFG2 = 5'h01;
	localparam logic [4:0] DBRA_PRI_CFG3 = 5'h02;
	localparam logic [4:0] DBRA_RXONOFF = 5'h09;
	localparam logic [4:0] DBRA_STRENGTH = 5'h0c;
	localparam logic [4:0] DBRA_SEC_CFG1 = 5'h0d;
	localparam logic [4:0] DBRA_SEC_CFG2 = 5'h0e;
	localparam logic [4:0] DBRA_SEC_CFG3 = 5'h0f;

	// Field positions
	localparam int unsigned DBRA_BANK_SEL_BIT = 7;
	localparam int unsigned DBRA_SOE_BIT = 7;
	localparam int unsigned DBRA_LOCK_BIT = 0;
	localparam int unsigned DBRA_LV_BIT = 1;
	localparam int unsigned DBRA_STR_HI_MSB = 7;
	localparam int unsigned DBRA_STR_HI_LSB = 4;
	localparam int unsigned DBRA_STR_LO_MSB = 3;
	localparam int unsigned DBRA_STR_LO_LSB = 0;

	// Reset values
	localparam logic [7:0] DBRA_BYTE_RST = 8'h00;
	localparam logic [1:0] DBRA_CNT_RST = 2'h0;
	localparam logic DBRA_BANK_RST = 1'b0;
	localparam logic DBRA_SOE_RST = 1'b0;

	typedef enum logic [1:0] {
		DBRA_IDLE = 2'b01,
		DBRA_XFER = 2'b10
	} dbra_state_t;
endpackage : dbra_pkg

// ===== src/dbra_byte_mem.sv
// Byte storage of the plain configuration bits, registered read port
`timescale 1ns/1ps
module dbra_byte_mem
	import dbra_pkg::*;
#(
	parameter int unsigned DEPTH = DBRA_MEM_DEPTH,
	parameter int unsigned WIDTH = DBRA_DW
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_we,
	input wire logic [$clog2(DEPTH)-1:0] i_waddr,
	input wire logic [WIDTH-1:0] i_wdata,
	input wire logic [$clog2(DEPTH)-1:0] i_raddr,
	output logic [WIDTH-1:0] o_rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Reset kept so that an unwritten byte never reads unknown
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= WIDTH'(DBRA_BYTE_RST);
			end
			o_rdata <= WIDTH'(DBRA_BYTE_RST);
		end else begin
			if (i_we) begin
				mem[i_waddr] <= i_wdata;
			end
			o_rdata <= mem[i_raddr];
		end
	end
endmodule : dbra_byte_mem

// ===== src/dbra_register_bank.sv
// Dual bank register map: address counter, mixed access bits, strength result
//
// Behaviour
// [RQ1] Result upper nibble is amplifier-output level
// [RQ2] Result lower nibble is filter-output level
// [RQ3] Read-only bits read back, writes ignored
// [RQ4] Byte organised space of 32 locations
// [RQ5] Start address and count; address steps per register
// [RQ6] Scans read or write; read-only writes dropped
// [RQ7] Counter wraps to zero past last register
// [RQ8] Both banks accessible whatever bank is active
// [RQ9] Clear-on-access bits cleared by any access
// [RQ10] Secondary mirrored bits show primary bank value
// [RQ11] Lock flag live, same from both banks
// [RQ12] Low-voltage flag latched, cleared by access
// [RQ13] Serial output enable written only via primary
// [RQ14] Strength bits straight from converters, bank-independent
// [RQ15] Bank select bit chooses active bank
// [RQ16] Clear-on-access value captured before clearing
`timescale 1ns/1ps
module dbra_register_bank
	import dbra_pkg::*;
#(
	parameter int unsigned MEM_DEPTH = DBRA_MEM_DEPTH
) (
	input wire logic I_MCLK,
	input wire logic I_RESET,
	input wire logic I_CMD_VALID,
	input wire logic [DBRA_AW-1:0] I_CMD_ADDR,
	input wire logic [DBRA_CNT_W-1:0] I_CMD_COUNT,
	input wire logic I_CMD_WRITE,
	input wire logic I_DATA_VALID,
	input wire logic [DBRA_DW-1:0] I_WDATA,
	input wire logic I_PLL_LOCK,
	input wire logic I_LOW_VOLTAGE,
	input wire logic [3:0] I_LNA_LEVEL,
	input wire logic [3:0] I_IF_LEVEL,
	output logic O_BUSY,
	output logic O_RDATA_VALID,
	output logic [DBRA_DW-1:0] O_RDATA,
	output logic O_BANK_SELECT,
	output logic O_SERIAL_OUTPUT_ENABLE,
	output logic O_LOW_VOLTAGE_LATCH
);
	localparam int unsigned MAW = $clog2(MEM_DEPTH);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic dbra_is_cfg3(input logic [DBRA_AW-1:0] a);
		dbra_is_cfg3 = (a == DBRA_PRI_CFG3) || (a == DBRA_SEC_CFG3);
	endfunction : dbra_is_cfg3

	function automatic logic dbra_in_range(input logic [DBRA_AW-1:0] a);
		dbra_in_range = (a <= DBRA_LAST_ADDR);
	endfunction : dbra_in_range

	function automatic logic [DBRA_DW-1:0] dbra_merge(
		input logic [DBRA_AW-1:0] a,
		input logic [DBRA_DW-1:0] stored,
		input logic lock,
		input logic lv,
		input logic serial_output_enable,
		input logic bank,
		input logic [DBRA_DW-1:0] strength
	);
		logic [DBRA_DW-1:0] d;
		d = stored;
		if (!dbra_in_range(a)) begin
			d = DBRA_BYTE_RST;
		end else if (a == DBRA_STRENGTH) begin
			d = strength; // [RQ14]
		end else if (dbra_is_cfg3(a)) begin
			d[DBRA_LOCK_BIT] = lock; // [RQ11]
			d[DBRA_LV_BIT] = lv; // [RQ9] [RQ12]
		end else if ((a == DBRA_PRI_CFG2) || (a == DBRA_SEC_CFG2)) begin
			d[DBRA_SOE_BIT] = serial_output_enable; // [RQ10] [RQ13]
		end else if (a == DBRA_RXONOFF) begin
			d[DBRA_BANK_SEL_BIT] = bank;
		end
		dbra_merge = d;
	endfunction : dbra_merge

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	// Converter nibbles may tear across a change; the value settles next cycle
	logic [DBRA_SYNC_W-1:0] sync1;
	logic [DBRA_SYNC_W-1:0] sync2;

	always_ff @(posedge I_MCLK or posedge I_RESET) begin
		if (I_RESET) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {I_PLL_LOCK, I_LOW_VOLTAGE, I_LNA_LEVEL, I_IF_LEVEL};
			sync2 <= sync1;
		end
	end

	wire logic lock_sync = sync2[DBRA_SYNC_W-1];
	wire logic lv_sync = sync2[DBRA_SYNC_W-2];
	wire logic [3:0] lna_sync = sync2[DBRA_STR_HI_MSB:DBRA_STR_HI_LSB];
	wire logic [3:0] if_sync = sync2[DBRA_STR_LO_MSB:DBRA_STR_LO_LSB];
	wire logic [DBRA_DW-1:0] strength = {lna_sync, if_sync}; // [RQ1] [RQ2] [RQ14]

	////////////////////////////////////////////////////////////////////////////
	// Transfer sequencer

	dbra_state_t state;
	dbra_state_t next_state;
	logic [DBRA_AW-1:0] cur_addr; // [RQ4]
	logic [DBRA_AW-1:0] next_addr;
	logic [DBRA_CNT_W-1:0] remaining;
	logic [DBRA_CNT_W-1:0] next_remaining;
	logic xfer_write;

	wire logic cmd_fire = I_CMD_VALID && (state == DBRA_IDLE);
	wire logic access = I_DATA_VALID && (state == DBRA_XFER);
	wire logic wr_fire = access && xfer_write;
	wire logic rd_fire = access && !xfer_write;
	wire logic last_reg = (remaining == DBRA_CNT_RST);
	// Past the last register, or beyond it, restart at address zero
	wire logic [DBRA_AW-1:0] step_addr = (cur_addr >= DBRA_LAST_ADDR) ? DBRA_FIRST_ADDR
		: cur_addr + DBRA_ADDR_STEP; // [RQ7]

	always_comb begin
		next_state = state;
		next_addr = cur_addr;
		next_remaining = remaining;
		unique case (state)
			DBRA_IDLE: begin
				if (cmd_fire) begin
					next_state = DBRA_XFER;
					next_addr = I_CMD_ADDR;
					next_remaining = I_CMD_COUNT; // [RQ5]
				end
			end
			DBRA_XFER: begin
				if (access) begin
					next_addr = step_addr; // [RQ5] [RQ6]
					next_remaining = remaining - DBRA_CNT_W'(1);
					if (last_reg) begin
						next_state = DBRA_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge I_MCLK or posedge I_RESET) begin
		if (I_RESET) begin
			state <= DBRA_IDLE;
			cur_addr <= DBRA_FIRST_ADDR;
			remaining <= DBRA_CNT_RST;
			xfer_write <= 1'b0;
		end else begin
			state <= next_state;
			cur_addr <= next_addr;
			remaining <= next_remaining;
			if (cmd_fire) begin
				xfer_write <= I_CMD_WRITE;
			end
		end
	end

	assign O_BUSY = (state == DBRA_XFER);

	////////////////////////////////////////////////////////////////////////////
	// Write decode and special bits

	wire logic addr_ok = dbra_in_range(cur_addr);
	// Result register is read-only: its writes never reach storage
	wire logic mem_we = wr_fire && addr_ok && (cur_addr != DBRA_STRENGTH); // [RQ3] [RQ6]
	wire logic wr_bank = wr_fire && (cur_addr == DBRA_RXONOFF); // [RQ15]
	wire logic wr_soe = wr_fire && (cur_addr == DBRA_PRI_CFG2); // [RQ13]
	wire logic cfg3_access = access && dbra_is_cfg3(cur_addr); // [RQ9]
	// A new detection outranks the clear of the same cycle
	wire logic next_lv = (O_LOW_VOLTAGE_LATCH && !cfg3_access) || lv_sync; // [RQ12] [RQ16]

	always_ff @(posedge I_MCLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_BANK_SELECT <= DBRA_BANK_RST;
			O_SERIAL_OUTPUT_ENABLE <= DBRA_SOE_RST;
			O_LOW_VOLTAGE_LATCH <= 1'b0;
		end else begin
			if (wr_bank) begin
				O_BANK_SELECT <= I_WDATA[DBRA_BANK_SEL_BIT]; // [RQ15]
			end
			if (wr_soe) begin
				O_SERIAL_OUTPUT_ENABLE <= I_WDATA[DBRA_SOE_BIT]; // [RQ13]
			end
			O_LOW_VOLTAGE_LATCH <= next_lv;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Storage and read pipeline

	logic [DBRA_DW-1:0] mem_rdata;

	// Both banks sit at their own addresses, so the active bank never gates access
	dbra_byte_mem #(
		.DEPTH(MEM_DEPTH),
		.WIDTH(DBRA_DW)
	) u_mem (
		.i_clk(I_MCLK),
		.i_reset(I_RESET),
		.i_we(mem_we), // [RQ8]
		.i_waddr(cur_addr[MAW-1:0]),
		.i_wdata(I_WDATA),
		.i_raddr(cur_addr[MAW-1:0]),
		.o_rdata(mem_rdata)
	);

	logic rd_valid1;
	logic [DBRA_AW-1:0] rd_addr1;
	logic [DBRA_AW-1:0] out_addr;
	logic snap_lock;
	logic snap_lv;
	logic snap_soe;
	logic snap_bank;
	logic [DBRA_DW-1:0] snap_strength;

	wire logic [DBRA_DW-1:0] merged = dbra_merge(rd_addr1, mem_rdata, snap_lock, snap_lv,
		snap_soe, snap_bank, snap_strength);

	// Snapshot taken in the access cycle, before the clear lands
	always_ff @(posedge I_MCLK or posedge I_RESET) begin
		if (I_RESET) begin
			rd_valid1 <= 1'b0;
			rd_addr1 <= DBRA_FIRST_ADDR;
			snap_lock <= 1'b0;
			snap_lv <= 1'b0;
			snap_soe <= DBRA_SOE_RST;
			snap_bank <= DBRA_BANK_RST;
			snap_strength <= DBRA_BYTE_RST;
		end else begin
			rd_valid1 <= rd_fire;
			rd_addr1 <= cur_addr;
			snap_lock <= lock_sync;
			snap_lv <= O_LOW_VOLTAGE_LATCH; // [RQ16]
			snap_soe <= O_SERIAL_OUTPUT_ENABLE;
			snap_bank <= O_BANK_SELECT;
			snap_strength <= strength;
		end
	end

	always_ff @(posedge I_MCLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_RDATA_VALID <= 1'b0;
			O_RDATA <= DBRA_BYTE_RST;
			out_addr <= DBRA_FIRST_ADDR;
		end else begin
			O_RDATA_VALID <= rd_valid1;
			out_addr <= rd_addr1;
			if (rd_valid1) begin
				O_RDATA <= merged;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking dbra_cb @(posedge I_MCLK);
	endclocking
	default disable iff (I_RESET);

	sequence seq_read_req;
		rd_fire;
	endsequence

	sequence seq_read_done;
		##2 O_RDATA_VALID;
	endsequence

	a_read_latency: assert property (seq_read_req |-> seq_read_done) // [RQ6]
		else $error("read data not returned two cycles after access");

	a_strength_upper: assert property ( // [RQ1]
		O_RDATA_VALID && (out_addr == DBRA_STRENGTH) |->
		O_RDATA[DBRA_STR_HI_MSB:DBRA_STR_HI_LSB] == $past(lna_sync, 2))
		else $error("strength upper nibble is not amplifier level");

	a_strength_lower: assert property ( // [RQ2]
		O_RDATA_VALID && (out_addr == DBRA_STRENGTH) |->
		O_RDATA[DBRA_STR_LO_MSB:DBRA_STR_LO_LSB] == $past(if_sync, 2))
		else $error("strength lower nibble is not filter level");

	a_readonly_write: assert property ( // [RQ3]
		wr_fire && (cur_addr == DBRA_STRENGTH) |=> $stable(u_mem.mem[DBRA_STRENGTH[MAW-1:0]]))
		else $error("write reached the read-only result register");

	a_addr_step: assert property ( // [RQ5]
		access && (cur_addr < DBRA_LAST_ADDR) |=> cur_addr == $past(cur_addr) + DBRA_ADDR_STEP)
		else $error("address did not step by one");

	a_addr_wrap: assert property ( // [RQ7]
		access && (cur_addr >= DBRA_LAST_ADDR) |=> cur_addr == DBRA_FIRST_ADDR)
		else $error("address did not wrap to zero");

	a_count_end: assert property ( // [RQ5]
		cmd_fire && (I_CMD_COUNT == DBRA_CNT_RST) ##1 access |=> !O_BUSY)
		else $error("single register transfer did not end");

	a_lv_clear: assert property ( // [RQ12]
		cfg3_access && !lv_sync |=> !O_LOW_VOLTAGE_LATCH)
		else $error("low voltage flag not cleared by access");

	a_lv_set_wins: assert property ( // [RQ16]
		lv_sync |=> O_LOW_VOLTAGE_LATCH)
		else $error("detection lost against clear");

	a_lock_live: assert property ( // [RQ11]
		O_RDATA_VALID && dbra_is_cfg3(out_addr) |-> O_RDATA[DBRA_LOCK_BIT] == $past(lock_sync, 2))
		else $error("lock flag read is not the live state");

	a_soe_mirror: assert property ( // [RQ13]
		wr_fire && (cur_addr == DBRA_SEC_CFG2) |=> $stable(O_SERIAL_OUTPUT_ENABLE))
		else $error("secondary bank changed serial output enable");

	a_bank_write: assert property ( // [RQ15]
		wr_bank |=> O_BANK_SELECT == $past(I_WDATA[DBRA_BANK_SEL_BIT]))
		else $error("bank select not taken from write");
endmodule : dbra_register_bank

// ===== bench/dbra_host_model.sv
// Host controller model driving command and data strobes of the register map
`timescale 1ns/1ps
module dbra_host_model
	import dbra_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_busy,
	input wire logic i_rdata_valid,
	input wire logic [DBRA_DW-1:0] i_rdata,
	output logic o_cmd_valid,
	output logic [DBRA_AW-1:0] o_cmd_addr,
	output logic [DBRA_CNT_W-1:0] o_cmd_count,
	output logic o_cmd_write,
	output logic o_data_valid,
	output logic [DBRA_DW-1:0] o_wdata
);
	logic [DBRA_DW-1:0] rd_q[$];

	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_addr = 5'h00;
		o_cmd_count = 2'h0;
		o_cmd_write = 1'b0;
		o_data_valid = 1'b0;
		o_wdata = 8'h00;
	end

	always @(negedge i_clk) begin
		if (i_rdata_valid === 1'b1) begin
			rd_q.push_back(i_rdata);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// One command, then count+1 strobes; gap idle cycles lets the host run slow
	task automatic xfer(input logic [4:0] addr, input logic [1:0] cnt, input logic wr, input logic [31:0] wd,
		input int gap, output logic [31:0] rd, output int nrd);
		int n;
		rd_q.delete();
		@(negedge i_clk);
		o_cmd_valid = 1'b1;
		o_cmd_addr = addr;
		o_cmd_count = cnt;
		o_cmd_write = wr;
		@(negedge i_clk);
		o_cmd_valid = 1'b0;
		// Released fields flip so a stale value is never mistaken for a live one
		o_cmd_addr = ~addr;
		o_cmd_count = ~cnt;
		o_cmd_write = ~wr;
		for (int i = 0; i <= cnt; i++) begin
			o_data_valid = 1'b1;
			o_wdata = wd[8*i +: 8];
			@(negedge i_clk);
			if (gap > 0 || i == cnt) begin
				o_data_valid = 1'b0;
				o_wdata = ~o_wdata;
				repeat (gap) @(negedge i_clk);
			end
		end
		n = 0;
		while (i_busy !== 1'b0 && n < 50) begin
			@(negedge i_clk);
			n++;
		end
		repeat (3) @(negedge i_clk);
		rd = 32'h0;
		foreach (rd_q[j]) begin
			if (j < 4) begin
				rd[8*j +: 8] = rd_q[j];
			end
		end
		nrd = rd_q.size();
	endtask : xfer
endmodule : dbra_host_model

// ===== bench/tb_top.sv
// Self-checking bench of the dual bank register map
`timescale 1ns/1ps
module tb_top;
	import dbra_pkg::*;
	localparam int LIMIT = 20000;
	logic mclk, reset, cmd_valid, cmd_write, data_valid, lock, lowv;
	logic busy, rdata_valid, bank, serial_output_enable, lv_latch, lv_exp;
	logic [4:0] cmd_addr;
	logic [1:0] cmd_count;
	logic [7:0] wdata, rdata;
	logic [3:0] lna, ifl;
	logic [7:0] shadow [0:31];
	logic [31:0] seed, r;
	int mismatches, n_compared, cycles, busy_len;

	dbra_register_bank i_dbra_register_bank (.I_MCLK(mclk), .I_RESET(reset), .I_CMD_VALID(cmd_valid),
		.I_CMD_ADDR(cmd_addr), .I_CMD_COUNT(cmd_count), .I_CMD_WRITE(cmd_write), .I_DATA_VALID(data_valid),
		.I_WDATA(wdata), .I_PLL_LOCK(lock), .I_LOW_VOLTAGE(lowv), .I_LNA_LEVEL(lna), .I_IF_LEVEL(ifl),
		.O_BUSY(busy), .O_RDATA_VALID(rdata_valid), .O_RDATA(rdata), .O_BANK_SELECT(bank),
		.O_SERIAL_OUTPUT_ENABLE(serial_output_enable), .O_LOW_VOLTAGE_LATCH(lv_latch));
	dbra_host_model i_dbra_host_model (.i_clk(mclk), .i_busy(busy), .i_rdata_valid(rdata_valid),
		.i_rdata(rdata), .o_cmd_valid(cmd_valid), .o_cmd_addr(cmd_addr), .o_cmd_count(cmd_count),
		.o_cmd_write(cmd_write), .o_data_valid(data_valid), .o_wdata(wdata));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] next_rand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : next_rand

	function automatic logic [4:0] step(input logic [4:0] a);
		return (a >= DBRA_LAST_ADDR) ? DBRA_FIRST_ADDR : a + DBRA_ADDR_STEP;
	endfunction : step

	// Shadow keeps every byte written up to the last register; live and mirrored bits are laid over it
	function automatic logic [7:0] exp_rd(input logic [4:0] a);
		logic [7:0] v;
		v = (a > DBRA_LAST_ADDR) ? 8'h00 : shadow[a];
		if (a == DBRA_STRENGTH) v = {lna, ifl};
		if (a == DBRA_SEC_CFG2) v[7] = shadow[DBRA_PRI_CFG2][7];
		if (a == DBRA_PRI_CFG3 || a == DBRA_SEC_CFG3) v[1:0] = {lv_exp, lock};
		return v;
	endfunction : exp_rd

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic do_xfer(input logic [4:0] a, input logic [1:0] c, input logic wr, input logic [31:0] wd,
		input int gap);
		logic [31:0] rd, ex;
		logic [4:0] p;
		int nrd, exp_len;
		p = a;
		ex = 32'h0;
		for (int i = 0; i <= c; i++) begin
			ex[8*i +: 8] = exp_rd(p);
			if (wr && p <= DBRA_LAST_ADDR) shadow[p] = wd[8*i +: 8];
			// A detection still present outranks the clear
			if ((p == DBRA_PRI_CFG3 || p == DBRA_SEC_CFG3) && !lowv) lv_exp = 1'b0;
			p = step(p);
		end
		busy_len = 0;
		i_dbra_host_model.xfer(a, c, wr, wd, gap, rd, nrd);
		exp_len = 1 + int'(c) * (1 + gap);
		check(8'(busy_len), 8'(exp_len), "busy length");
		if (!wr) begin
			check(nrd[7:0], {6'h00, c} + 8'h01, "read count");
			for (int i = 0; i <= c; i++) begin
				check(rd[8*i +: 8], ex[8*i +: 8], "read byte");
			end
		end
		check({7'h00, bank}, {7'h00, shadow[DBRA_RXONOFF][7]}, "bank select");
		check({7'h00, serial_output_enable}, {7'h00, shadow[DBRA_PRI_CFG2][7]}, "serial out enable");
		check({7'h00, lv_latch}, {7'h00, lv_exp}, "low voltage latch");
	endtask : do_xfer

	task automatic scan_all();
		for (int a = 0; a < 32; a += 4) begin
			do_xfer(a[4:0], 2'h3, 1'b0, 32'h0, a % 3);
		end
	endtask : scan_all

	task automatic lv_pulse();
		lowv = 1'b1;
		repeat (4) @(negedge mclk);
		lowv = 1'b0;
		repeat (4) @(negedge mclk);
		lv_exp = 1'b1;
	endtask : lv_pulse

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report

	always @(negedge mclk) begin
		if (busy === 1'b1) begin
			busy_len++;
		end
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			$display("[ERR] %0t run did not finish", $time);
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		reset = 1'b1;
		lock = 1'b0;
		lowv = 1'b0;
		lna = 4'h0;
		ifl = 4'h0;
		lv_exp = 1'b0;
		seed = 32'h1d9e;
		mismatches = 0;
		n_compared = 0;
		cycles = 0;
		foreach (shadow[k]) shadow[k] = 8'h00;
		repeat (20) @(negedge mclk);
		reset = 1'b0;
		scan_all();
		$display("test reset_scan done");
		do_xfer(DBRA_PRI_CFG2, 2'h0, 1'b1, 32'h80, 0);
		do_xfer(DBRA_SEC_CFG2, 2'h0, 1'b1, 32'h00, 1);
		do_xfer(DBRA_RXONOFF, 2'h0, 1'b1, 32'h80, 0);
		do_xfer(5'h1f, 2'h1, 1'b1, 32'hffa5, 0);
		do_xfer(DBRA_STRENGTH, 2'h3, 1'b1, next_rand(), 0);
		scan_all();
		$display("test corner_writes done");
		for (int k = 0; k < 40; k++) begin
			r = next_rand();
			lna = r[3:0];
			ifl = r[7:4];
			lock = r[8];
			repeat (3) @(negedge mclk);
			do_xfer(r[20:16], r[22:21], 1'b1, next_rand(), int'(r[25:24]));
			do_xfer(r[20:16], r[22:21], 1'b0, 32'h0, int'(r[27:26]));
		end
		$display("test random_scans done");
		lv_pulse();
		check({7'h00, lv_latch}, 8'h01, "latch set");
		do_xfer(DBRA_SEC_CFG3, 2'h0, 1'b0, 32'h0, 0);
		lv_pulse();
		do_xfer(DBRA_PRI_CFG3, 2'h0, 1'b1, 32'hff, 0);
		do_xfer(DBRA_PRI_CFG3, 2'h0, 1'b0, 32'h0, 0);
		lowv = 1'b1;
		repeat (3) @(negedge mclk);
		lv_exp = 1'b1;
		do_xfer(DBRA_SEC_CFG3, 2'h0, 1'b0, 32'h0, 0);
		lowv = 1'b0;
		repeat (3) @(negedge mclk);
		do_xfer(DBRA_PRI_CFG3, 2'h0, 1'b0, 32'h0, 0);
		$display("test low_voltage done");
		final_report();
	end
endmodule : tb_top
